// ---- src/phase_mode_pkg.sv ----
package phase_mode_pkg;
  typedef enum logic [1:0] {
    MODE_FULL = 2'b00,
    MODE_SHED = 2'b01,
    MODE_LOW = 2'b10
  } op_mode_t;

  typedef enum logic [1:0] {
    RUN_OFF = 2'b00,
    RUN_ON = 2'b01,
    RUN_TRIP = 2'b10
  } run_state_t;

  typedef enum logic [1:0] {
    ZONE_LOW = 2'b00,
    ZONE_MID = 2'b01,
    ZONE_HIGH = 2'b10
  } shed_zone_t;

  localparam int PHASES = 4;
  localparam int MV_W = 12;
  localparam int KOHM_W = 9;
  localparam logic [2:0] PH_ONE = 3'h1;
  localparam logic [2:0] PH_TWO = 3'h2;
  localparam logic [2:0] PH_THREE = 3'h3;
  localparam logic [2:0] PH_FOUR = 3'h4;
  // mode input quantiser, midway between ground, 1 V and 1.8 V
  localparam logic [11:0] PSI_LOW_MAX_MV = 12'h1F4;
  localparam logic [11:0] PSI_SHED_MAX_MV = 12'h578;
  // strap current 10 uA through kilohms gives 10 mV per kilohm
  localparam logic [3:0] SHED_MV_PER_KOHM = 4'hA;
  localparam int SHED_LOW_SHIFT = 2;
  localparam int SHED_HIGH_SHIFT = 1;
  localparam logic [11:0] OCP_FULL_MV = 12'h834;
  localparam int OCP_SCALE_SHIFT = 3;
  // total limit scale in eighths, by missing phases
  localparam logic [3:0] OCP_EIGHTHS [0:3] = '{4'h8, 4'h6, 4'h4, 4'h3};
  localparam logic [8:0] INTERLEAVE_DEG [1:4] = '{9'h168, 9'h0B4, 9'h078, 9'h05A};
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // hysteresis strap: top kilohm of each band, in 20 mV steps
  localparam int HYS_BANDS = 14;
  localparam logic [8:0] HYS_BAND_MAX [0:13] = '{9'h013, 9'h01E, 9'h02E, 9'h03E,
    9'h04B, 9'h05B, 9'h07D, 9'h09F, 9'h0AE, 9'h0BE, 9'h0CF, 9'h0DF, 9'h100, 9'h1FF};
  localparam logic [2:0] HYS_STEPS [0:13] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2,
    3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  localparam int HYS_MID_FIRST = 7;
  localparam logic [4:0] HYS_STEP_MV = 5'h14;
  localparam logic [10:0] FREQ_KHZ [0:7] = '{11'h0C8, 11'h12C, 11'h190, 11'h1F4,
    11'h258, 11'h3E8, 11'h5DC, 11'h7D0};
  localparam int ADDR_BANDS = 5;
  localparam logic [6:0] SMBUS_ADDR [0:4] = '{7'h48, 7'h4A, 7'h4C, 7'h4E, 7'h40};
endpackage

// ---- src/strap_if.sv ----
`timescale 1ns/100ps
interface strap_if;
  logic latch;
  logic [8:0] hys_kohm;
  logic [2:0] freq_ratio;
  logic [2:0] addr_band;
  logic [1:0] lpc_ratio;
  logic [1:0] lpc_band;
  logic [2:0] sense_pulled;
  logic [2:0] max_phases;
  logic [2:0] cold_phases;
  logic [2:0] warm_phases;
  logic [7:0] hys_mv;
  logic mid_drive;
  logic [10:0] freq_khz;
  logic [6:0] smbus_addr;

  modport ctrl (
    output latch, hys_kohm, freq_ratio, addr_band, lpc_ratio, lpc_band, sense_pulled,
    input max_phases, cold_phases, warm_phases, hys_mv, mid_drive, freq_khz, smbus_addr
  );
  modport decoder (
    input latch, hys_kohm, freq_ratio, addr_band, lpc_ratio, lpc_band, sense_pulled,
    output max_phases, cold_phases, warm_phases, hys_mv, mid_drive, freq_khz, smbus_addr
  );
endinterface

// ---- src/strap_decoder.sv ----
`timescale 1ns/100ps
module strap_decoder (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  strap_if.decoder straps
);
  logic [2:0] max_ff, nxt_max;
  logic [2:0] cold_ff, nxt_cold;
  logic [2:0] warm_ff, nxt_warm;
  logic [7:0] hys_ff, nxt_hys;
  logic mid_ff, nxt_mid;
  logic [10:0] freq_ff, nxt_freq;
  logic [6:0] addr_ff, nxt_addr;

  always_comb begin
    logic found;
    found = 1'b0;
    nxt_max = max_ff;
    nxt_cold = cold_ff;
    nxt_warm = warm_ff;
    nxt_hys = hys_ff;
    nxt_mid = mid_ff;
    nxt_freq = freq_ff;
    nxt_addr = addr_ff;
    if (straps.latch) begin
      // the second phase pulled wins: fewest phases
      if (straps.sense_pulled[0]) begin
        nxt_max = phase_mode_pkg::PH_ONE; // [R14]
      end else if (straps.sense_pulled[1]) begin
        nxt_max = phase_mode_pkg::PH_TWO; // [R14]
      end else if (straps.sense_pulled[2]) begin
        nxt_max = phase_mode_pkg::PH_THREE; // [R14]
      end else begin
        nxt_max = phase_mode_pkg::PH_FOUR; // [R14]
      end
      nxt_cold = {1'b0, straps.lpc_ratio} + phase_mode_pkg::PH_ONE; // [R5]
      nxt_warm = {1'b0, straps.lpc_band} + phase_mode_pkg::PH_ONE; // [R5] [R2]
      for (int i = 0; i < phase_mode_pkg::HYS_BANDS; i++) begin
        if (!found && straps.hys_kohm <= phase_mode_pkg::HYS_BAND_MAX[i]) begin
          found = 1'b1;
          nxt_hys = 8'(phase_mode_pkg::HYS_STEPS[i] * phase_mode_pkg::HYS_STEP_MV); // [R11]
          nxt_mid = (i >= phase_mode_pkg::HYS_MID_FIRST); // [R11]
        end
      end
      nxt_freq = phase_mode_pkg::FREQ_KHZ[straps.freq_ratio]; // [R13]
      // bands past the table use the first address
      if (int'(straps.addr_band) < phase_mode_pkg::ADDR_BANDS) begin
        nxt_addr = phase_mode_pkg::SMBUS_ADDR[straps.addr_band]; // [R13]
      end else begin
        nxt_addr = phase_mode_pkg::SMBUS_ADDR[0];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      max_ff <= phase_mode_pkg::PH_FOUR;
      cold_ff <= phase_mode_pkg::PH_ONE;
      warm_ff <= phase_mode_pkg::PH_ONE;
      hys_ff <= 8'h14;
      mid_ff <= 1'b0;
      freq_ff <= phase_mode_pkg::FREQ_KHZ[0];
      addr_ff <= phase_mode_pkg::SMBUS_ADDR[0];
    end else begin
      max_ff <= nxt_max;
      cold_ff <= nxt_cold;
      warm_ff <= nxt_warm;
      hys_ff <= nxt_hys;
      mid_ff <= nxt_mid;
      freq_ff <= nxt_freq;
      addr_ff <= nxt_addr;
    end
  end

  assign straps.max_phases = max_ff;
  assign straps.cold_phases = cold_ff;
  assign straps.warm_phases = warm_ff;
  assign straps.hys_mv = hys_ff;
  assign straps.mid_drive = mid_ff;
  assign straps.freq_khz = freq_ff;
  assign straps.smbus_addr = addr_ff;
endmodule // strap_decoder

// ---- src/phase_mode_control.sv ----
// Notes on behaviour
// (R1) three modes from power state level: full at 1.8V, shedding at 1V, low at ground
// (R2) low-phase mode has cold-boot and warm-boot variants with own phase counts
// (R3) power state low on the very first start-up gives cold boot
// (R4) later enable start-ups with power state low give warm boot
// (R5) divider ratio picks cold count one to four; resistance band picks warm count
// (R6) shedding runs only at shedding level after power good and a voltage code pulse
// (R7) shedding: one phase below low, two between, four above high threshold
// (R8) thresholds from SMBus or straps: 10uA times R over four, over two
// (R9) low zone count not below higher zone count forces full-phase operation
// (R10) active phases always evenly interleaved
// (R11) second strap sets hysteresis 20-140mV and middle-state drive by band
// (R12) middle drive on: drive middle level; else float to high impedance
// (R13) address/frequency strap selects eight frequencies and five SMBus addresses
// (R14) maximum phase count latched at each power-on from pulled sense pins
// (R15) active count set by mode or SMBus, never above latched maximum
// (R16) phase over its channel limit is held to average current, no shutdown
// (R17) total over-current trips above 2.1V on the current monitor at full phase
// (R18) total limit lowered when active count drops below hardware count
// (R19) total limit scale 1, 3/4, 1/2, 3/8 by missing phases
// (R20) total over-current: all switches off, latched till enable restart or power-on
// (R21) first-boot flag set by power-on, cleared after first enabled start-up
// (R22) power state level quantised into three codes, applied next control cycle
`timescale 1ns/100ps
module phase_mode_control #(
  parameter int PHASES = phase_mode_pkg::PHASES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic i_power_good,
  input wire logic i_voltage_code_input,
  input wire logic [2:0] i_phase_sense_input_pulled,
  input wire logic [11:0] i_power_state_input_mv,
  input wire logic [11:0] i_total_current_monitor_mv,
  input wire logic [PHASES*12-1:0] i_phase_sense_mv,
  input wire logic [11:0] i_per_channel_limit_pin_mv,
  input wire logic [8:0] i_second_phase_drive_strap_kohm,
  input wire logic [8:0] i_third_phase_drive_strap_kohm,
  input wire logic [8:0] i_fourth_phase_drive_strap_kohm,
  input wire logic [2:0] i_address_frequency_strap_ratio,
  input wire logic [2:0] i_address_frequency_strap_band,
  input wire logic [1:0] i_low_phase_count_pin_ratio,
  input wire logic [1:0] i_low_phase_count_pin_band,
  input wire logic i_smbus_threshold_valid,
  input wire logic [11:0] i_smbus_shed_threshold_low_mv,
  input wire logic [11:0] i_smbus_shed_threshold_high_mv,
  input wire logic [2:0] i_zone_low_phases,
  input wire logic [2:0] i_zone_mid_phases,
  input wire logic i_smbus_phase_valid,
  input wire logic [2:0] i_smbus_phases,
  input wire logic [PHASES-1:0] i_pwm_request,
  input wire logic [PHASES-1:0] i_pwm_middle_request,
  output logic [1:0] o_mode,
  output logic o_running,
  output logic o_cold_boot,
  output logic o_shed_active,
  output logic [2:0] o_max_phases,
  output logic [2:0] o_active_phases,
  output logic [PHASES-1:0] o_phase_enable,
  output logic [8:0] o_interleave_deg,
  output logic [7:0] o_shed_hysteresis_mv,
  output logic o_middle_drive_enable,
  output logic [10:0] o_switch_freq_khz,
  output logic [6:0] o_smbus_address,
  output logic [11:0] o_ocp_threshold_mv,
  output logic o_over_current_protection,
  output logic [PHASES-1:0] o_channel_limit,
  output logic [PHASES-1:0] o_pwm_out,
  output logic [PHASES-1:0] o_pwm_oe,
  output logic [PHASES-1:0] o_pwm_middle
);
  ////////////////////////////////////////
  // pin synchronisers
  logic [5:0] sync1_ff, nxt_sync1;
  logic [5:0] sync2_ff, nxt_sync2;
  logic vid_prev_ff, nxt_vid_prev;
  logic en_s, power_good_s, vid_s, vid_edge;

  always_comb begin
    nxt_sync1 = {i_phase_sense_input_pulled, i_voltage_code_input, i_power_good, i_enable};
    nxt_sync2 = sync1_ff;
    nxt_vid_prev = sync2_ff[2];
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      vid_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      vid_prev_ff <= nxt_vid_prev;
    end
  end

  assign en_s = sync2_ff[0];
  assign power_good_s = sync2_ff[1];
  assign vid_s = sync2_ff[2];
  assign vid_edge = vid_s & ~vid_prev_ff;

  ////////////////////////////////////////
  // strap capture after reset
  strap_if straps ();
  logic [1:0] settle_ff, nxt_settle;
  logic latched_ff, nxt_latched;
  logic [11:0] strap_low_ff, nxt_strap_low;
  logic [11:0] strap_high_ff, nxt_strap_high;

  strap_decoder u_strap_decoder (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .straps(straps)
  );

  // settle lets the pin synchroniser fill before the one-time latch
  always_comb begin
    nxt_settle = settle_ff;
    nxt_latched = latched_ff;
    nxt_strap_low = strap_low_ff;
    nxt_strap_high = strap_high_ff;
    if (!latched_ff) begin
      if (settle_ff == phase_mode_pkg::STRAP_SETTLE) begin
        nxt_latched = 1'b1; // [R14]
        nxt_strap_low = 12'((13'(i_third_phase_drive_strap_kohm)
          * phase_mode_pkg::SHED_MV_PER_KOHM) >> phase_mode_pkg::SHED_LOW_SHIFT); // [R8]
        nxt_strap_high = 12'((13'(i_fourth_phase_drive_strap_kohm)
          * phase_mode_pkg::SHED_MV_PER_KOHM) >> phase_mode_pkg::SHED_HIGH_SHIFT); // [R8]
      end else begin
        nxt_settle = settle_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      settle_ff <= 2'h0;
      latched_ff <= 1'b0;
      strap_low_ff <= 12'h000;
      strap_high_ff <= 12'h000;
    end else begin
      settle_ff <= nxt_settle;
      latched_ff <= nxt_latched;
      strap_low_ff <= nxt_strap_low;
      strap_high_ff <= nxt_strap_high;
    end
  end

  assign straps.latch = ~latched_ff & (settle_ff == phase_mode_pkg::STRAP_SETTLE);
  assign straps.sense_pulled = sync2_ff[5:3];
  assign straps.hys_kohm = i_second_phase_drive_strap_kohm;
  assign straps.freq_ratio = i_address_frequency_strap_ratio;
  assign straps.addr_band = i_address_frequency_strap_band;
  assign straps.lpc_ratio = i_low_phase_count_pin_ratio;
  assign straps.lpc_band = i_low_phase_count_pin_band;

  ////////////////////////////////////////
  // mode, boot variant, run state and shedding
  phase_mode_pkg::op_mode_t mode_ff, nxt_mode;
  phase_mode_pkg::run_state_t run_ff, nxt_run;
  phase_mode_pkg::shed_zone_t zone_ff, nxt_zone;
  logic first_boot_ff, nxt_first_boot;
  logic warm_ff, nxt_warm;
  logic vid_seen_ff, nxt_vid_seen;
  logic [2:0] active_ff, nxt_active;
  logic [11:0] ocp_thr_ff, nxt_ocp_thr;
  logic shed_on, ocp_hit, run_on;
  logic [11:0] thr_low, thr_high;
  logic [12:0] total_current_monitor_up;
  logic [2:0] want, zone_ph;
  logic [15:0] ocp_prod;
  logic [2:0] missing;

  assign shed_on = (mode_ff == phase_mode_pkg::MODE_SHED) & power_good_s & vid_seen_ff; // [R6]
  assign thr_low = i_smbus_threshold_valid ? i_smbus_shed_threshold_low_mv : strap_low_ff; // [R8]
  assign thr_high = i_smbus_threshold_valid ? i_smbus_shed_threshold_high_mv : strap_high_ff;
  assign total_current_monitor_up = 13'(i_total_current_monitor_mv) + 13'(straps.hys_mv);
  assign run_on = (run_ff == phase_mode_pkg::RUN_ON);
  assign ocp_hit = run_on & (i_total_current_monitor_mv > ocp_thr_ff);

  always_comb begin
    nxt_mode = phase_mode_pkg::MODE_FULL;
    if (i_power_state_input_mv < phase_mode_pkg::PSI_LOW_MAX_MV) begin
      nxt_mode = phase_mode_pkg::MODE_LOW; // [R22] [R1]
    end else if (i_power_state_input_mv < phase_mode_pkg::PSI_SHED_MAX_MV) begin
      nxt_mode = phase_mode_pkg::MODE_SHED; // [R22] [R1]
    end
    // a pulse only counts once power good is up; losing power good forgets it
    nxt_vid_seen = power_good_s & (vid_seen_ff | vid_edge); // [R6]
    nxt_run = run_ff;
    nxt_first_boot = first_boot_ff;
    nxt_warm = warm_ff;
    unique case (run_ff)
      phase_mode_pkg::RUN_OFF: begin
        if (en_s && latched_ff) begin
          nxt_run = phase_mode_pkg::RUN_ON;
          nxt_warm = ~first_boot_ff; // [R3] [R4] [R21]
          nxt_first_boot = 1'b0; // [R21]
        end
      end
      phase_mode_pkg::RUN_ON: begin
        if (!en_s) begin
          nxt_run = phase_mode_pkg::RUN_OFF;
        end else if (ocp_hit) begin
          nxt_run = phase_mode_pkg::RUN_TRIP; // [R17] [R20]
        end
      end
      phase_mode_pkg::RUN_TRIP: begin
        if (!en_s) begin
          nxt_run = phase_mode_pkg::RUN_OFF; // [R20]
        end
      end
      default: nxt_run = phase_mode_pkg::RUN_OFF;
    endcase
    // hysteresis on the way down only, so a zone never chatters
    nxt_zone = zone_ff;
    unique case (zone_ff)
      phase_mode_pkg::ZONE_LOW: begin
        if (i_total_current_monitor_mv > thr_high) begin
          nxt_zone = phase_mode_pkg::ZONE_HIGH; // [R7]
        end else if (i_total_current_monitor_mv > thr_low) begin
          nxt_zone = phase_mode_pkg::ZONE_MID; // [R7]
        end
      end
      phase_mode_pkg::ZONE_MID: begin
        if (i_total_current_monitor_mv > thr_high) begin
          nxt_zone = phase_mode_pkg::ZONE_HIGH; // [R7]
        end else if (total_current_monitor_up < 13'(thr_low)) begin
          nxt_zone = phase_mode_pkg::ZONE_LOW; // [R7] [R11]
        end
      end
      phase_mode_pkg::ZONE_HIGH: begin
        if (total_current_monitor_up < 13'(thr_low)) begin
          nxt_zone = phase_mode_pkg::ZONE_LOW; // [R7]
        end else if (total_current_monitor_up < 13'(thr_high)) begin
          nxt_zone = phase_mode_pkg::ZONE_MID; // [R7] [R11]
        end
      end
      default: nxt_zone = phase_mode_pkg::ZONE_LOW;
    endcase
    if (!shed_on) begin
      nxt_zone = phase_mode_pkg::ZONE_HIGH;
    end
    if (i_zone_low_phases >= i_zone_mid_phases) begin
      zone_ph = straps.max_phases; // [R9]
    end else if (zone_ff == phase_mode_pkg::ZONE_LOW) begin
      zone_ph = i_zone_low_phases;
    end else if (zone_ff == phase_mode_pkg::ZONE_MID) begin
      zone_ph = i_zone_mid_phases;
    end else begin
      zone_ph = straps.max_phases;
    end
    unique case (mode_ff)
      phase_mode_pkg::MODE_LOW: want = warm_ff ? straps.warm_phases : straps.cold_phases; // [R2]
      phase_mode_pkg::MODE_SHED: want = shed_on ? zone_ph : straps.max_phases; // [R6] [R7]
      default: want = i_smbus_phase_valid ? i_smbus_phases : straps.max_phases; // [R15]
    endcase
    if (want > straps.max_phases) begin
      want = straps.max_phases; // [R15]
    end
    if (want < phase_mode_pkg::PH_ONE) begin
      want = phase_mode_pkg::PH_ONE;
    end
    nxt_active = want;
    missing = straps.max_phases - active_ff;
    ocp_prod = 16'(phase_mode_pkg::OCP_FULL_MV) * 16'(phase_mode_pkg::OCP_EIGHTHS[missing[1:0]]);
    nxt_ocp_thr = 12'(ocp_prod >> phase_mode_pkg::OCP_SCALE_SHIFT); // [R18] [R19]
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      mode_ff <= phase_mode_pkg::MODE_FULL;
      run_ff <= phase_mode_pkg::RUN_OFF;
      zone_ff <= phase_mode_pkg::ZONE_HIGH;
      first_boot_ff <= 1'b1; // [R21]
      warm_ff <= 1'b0;
      vid_seen_ff <= 1'b0;
      active_ff <= phase_mode_pkg::PH_FOUR;
      ocp_thr_ff <= phase_mode_pkg::OCP_FULL_MV;
    end else begin
      mode_ff <= nxt_mode;
      run_ff <= nxt_run;
      zone_ff <= nxt_zone;
      first_boot_ff <= nxt_first_boot;
      warm_ff <= nxt_warm;
      vid_seen_ff <= nxt_vid_seen;
      active_ff <= nxt_active;
      ocp_thr_ff <= nxt_ocp_thr;
    end
  end

  ////////////////////////////////////////
  // per-phase drive
  logic [PHASES-1:0] pwm_ff, nxt_pwm;
  logic [PHASES-1:0] oe_ff, nxt_oe;
  logic [PHASES-1:0] mid_ff, nxt_mid;
  logic [PHASES-1:0] lim_ff, nxt_lim;
  logic [PHASES-1:0] enab;

  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    logic over, idle;
    // active phases are contiguous, so the step is 360/n
    assign enab[p] = run_on & (3'(p) < active_ff); // [R10]
    assign over = i_phase_sense_mv[p*12 +: 12] > i_per_channel_limit_pin_mv;
    // idle or limited phase: both switches off, middle level
    assign idle = ~enab[p] | i_pwm_middle_request[p] | (over & i_pwm_request[p]);
    always_comb begin
      nxt_lim[p] = enab[p] & over; // [R16]
      nxt_pwm[p] = ~idle & i_pwm_request[p]; // [R16] [R20]
      nxt_mid[p] = idle & straps.mid_drive; // [R12]
      nxt_oe[p] = ~idle | straps.mid_drive; // [R12]
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pwm_ff <= '0;
      oe_ff <= '0;
      mid_ff <= '0;
      lim_ff <= '0;
    end else begin
      pwm_ff <= nxt_pwm;
      oe_ff <= nxt_oe;
      mid_ff <= nxt_mid;
      lim_ff <= nxt_lim;
    end
  end

  assign o_mode = mode_ff;
  assign o_running = run_on;
  assign o_cold_boot = (mode_ff == phase_mode_pkg::MODE_LOW) & ~warm_ff; // [R3]
  assign o_shed_active = shed_on;
  assign o_max_phases = straps.max_phases;
  assign o_active_phases = active_ff;
  assign o_phase_enable = enab;
  assign o_interleave_deg = phase_mode_pkg::INTERLEAVE_DEG[active_ff]; // [R10]
  assign o_shed_hysteresis_mv = straps.hys_mv;
  assign o_middle_drive_enable = straps.mid_drive;
  assign o_switch_freq_khz = straps.freq_khz;
  assign o_smbus_address = straps.smbus_addr;
  assign o_ocp_threshold_mv = ocp_thr_ff;
  assign o_over_current_protection = (run_ff == phase_mode_pkg::RUN_TRIP); // [R20]
  assign o_channel_limit = lim_ff;
  assign o_pwm_out = pwm_ff;
  assign o_pwm_oe = oe_ff;
  assign o_pwm_middle = mid_ff;
endmodule // phase_mode_control

// ---- verification/phase_mode_control_sva.sv ----
`timescale 1ns/100ps
module phase_mode_control_sva #(
  parameter int PHASES = phase_mode_pkg::PHASES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic [11:0] i_power_state_input_mv,
  input wire logic [11:0] i_total_current_monitor_mv,
  input wire logic [PHASES*12-1:0] i_phase_sense_mv,
  input wire logic [11:0] i_per_channel_limit_pin_mv,
  input wire logic [1:0] o_mode,
  input wire logic o_running,
  input wire logic [2:0] o_max_phases,
  input wire logic [2:0] o_active_phases,
  input wire logic [PHASES-1:0] o_phase_enable,
  input wire logic [11:0] o_ocp_threshold_mv,
  input wire logic o_over_current_protection,
  input wire logic o_middle_drive_enable,
  input wire logic [PHASES-1:0] o_channel_limit,
  input wire logic [PHASES-1:0] o_pwm_out,
  input wire logic [PHASES-1:0] o_pwm_oe,
  input wire logic [PHASES-1:0] o_pwm_middle
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  function automatic logic [1:0] mode_of(input logic [11:0] mv);
    return (mv < 12'h1F4) ? 2'h2 : ((mv < 12'h578) ? 2'h1 : 2'h0);
  endfunction
  localparam logic [11:0] OCP_MV [0:3] = '{12'h834, 12'h627, 12'h41A, 12'h313};
  ////////////////////////////////////////
  mode_level_a: assert property (
    !$past(i_reset) |-> o_mode == mode_of($past(i_power_state_input_mv))) else $error("mode");
  phase_mask_a: assert property (
    o_phase_enable == (o_running ? PHASES'((1 << o_active_phases) - 1) : '0))
    else $error("phase enable");
  // count clamps one edge after the straps latch
  active_bound_a: assert property (
    o_running && $past(o_running) |-> o_active_phases >= 3'h1 && o_active_phases <= o_max_phases)
    else $error("active count");
  ocp_scale_a: assert property (
    !$past(i_reset) && $past(o_active_phases) <= $past(o_max_phases)
    |-> o_ocp_threshold_mv == OCP_MV[2'($past(o_max_phases) - $past(o_active_phases))])
    else $error("ocp threshold");
  ocp_trip_a: assert property (
    o_running && i_enable && $past(i_enable) && $past(i_enable, 2)
    && i_total_current_monitor_mv > o_ocp_threshold_mv |=> o_over_current_protection)
    else $error("no trip");
  ocp_latch_a: assert property (
    o_over_current_protection && i_enable && $past(i_enable) && $past(i_enable, 2)
    |=> o_over_current_protection) else $error("trip released");
  ocp_off_a: assert property (
    o_over_current_protection |=> o_pwm_out == '0) else $error("switch on in trip");
  mid_drive_a: assert property (
    $stable(o_middle_drive_enable) |-> (o_middle_drive_enable ? o_pwm_oe == '1 : o_pwm_middle == '0))
    else $error("middle level");
  ch_limit_a: assert property (
    o_phase_enable[0] && i_phase_sense_mv[11:0] > i_per_channel_limit_pin_mv
    |=> o_channel_limit[0] && !o_pwm_out[0] && o_running) else $error("channel limit");
  max_hold_a: assert property (
    o_running && $past(o_running) |-> $stable(o_max_phases)) else $error("max moved");
endmodule // phase_mode_control_sva

bind phase_mode_control phase_mode_control_sva #(.PHASES(PHASES)) i_sva (.*);

// ---- verification/power_stage_model.sv ----
`timescale 1ns/100ps
module power_stage_model #(
  parameter int PHASES = phase_mode_pkg::PHASES
) (
  input wire logic [PHASES-1:0] i_pwm_out,
  input wire logic [PHASES-1:0] i_pwm_oe,
  input wire logic [PHASES-1:0] i_pwm_middle,
  input wire logic [PHASES*12-1:0] i_load_mv,
  output logic [PHASES*12-1:0] o_phase_sense_mv,
  output logic [PHASES-1:0] o_pin_mid
);
  // sense reports load even on a gated phase
  assign o_phase_sense_mv = i_load_mv;
  // a floating pin sits at the middle level
  assign o_pin_mid = ~i_pwm_oe | (i_pwm_middle & ~i_pwm_out);
endmodule // power_stage_model

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  localparam int PHASES = phase_mode_pkg::PHASES;
  logic i_ref_clk = 1'b0, i_reset = 1'b1, i_enable = 1'b0, i_power_good = 1'b0;
  logic i_voltage_code_input = 1'b0, i_smbus_threshold_valid = 1'b0, i_smbus_phase_valid = 1'b0;
  logic [2:0] i_phase_sense_input_pulled = 3'h0, i_smbus_phases = 3'h4;
  logic [2:0] i_zone_low_phases = 3'h1, i_zone_mid_phases = 3'h2;
  logic [11:0] i_power_state_input_mv = 12'h000, i_total_current_monitor_mv = 12'h064;
  logic [11:0] i_per_channel_limit_pin_mv = 12'h200;
  logic [11:0] i_smbus_shed_threshold_low_mv = 12'h000, i_smbus_shed_threshold_high_mv = 12'h000;
  logic [PHASES*12-1:0] i_phase_sense_mv, load_mv = {PHASES{12'h100}};
  logic [8:0] i_second_phase_drive_strap_kohm = 9'h064, i_third_phase_drive_strap_kohm = 9'h078;
  logic [8:0] i_fourth_phase_drive_strap_kohm = 9'h078;
  logic [2:0] i_address_frequency_strap_ratio = 3'h0, i_address_frequency_strap_band = 3'h0;
  logic [1:0] i_low_phase_count_pin_ratio = 2'h1, i_low_phase_count_pin_band = 2'h2, o_mode;
  logic [PHASES-1:0] i_pwm_request = '1, i_pwm_middle_request = '0, pin_mid;
  logic o_running, o_cold_boot, o_shed_active, o_middle_drive_enable, o_over_current_protection;
  logic [2:0] o_max_phases, o_active_phases;
  logic [8:0] o_interleave_deg;
  logic [7:0] o_shed_hysteresis_mv;
  logic [10:0] o_switch_freq_khz;
  logic [6:0] o_smbus_address;
  logic [11:0] o_ocp_threshold_mv;
  logic [PHASES-1:0] o_phase_enable, o_channel_limit, o_pwm_out, o_pwm_oe, o_pwm_middle;
  int n_errors = 0, n_checks = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  phase_mode_control #(.PHASES(PHASES)) i_dut (.*);
  power_stage_model #(.PHASES(PHASES)) i_stage (
    .i_pwm_out(o_pwm_out),
    .i_pwm_oe(o_pwm_oe),
    .i_pwm_middle(o_pwm_middle),
    .i_load_mv(load_mv),
    .o_phase_sense_mv(i_phase_sense_mv),
    .o_pin_mid(pin_mid)
  );
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  // bounded poll; threshold trails the count by one edge
  task automatic wait_active(input logic [2:0] exp);
    int k = 0;
    while (o_active_phases !== exp && k < 80) begin
      cyc(1);
      k++;
    end
    chk(o_active_phases, exp);
    if (k == 80) stop_test();
    else cyc(2);
  endtask
  ////////////////////////////////////////
  // a strap moved after the latch must not reach the outputs
  task automatic t_straps(input logic [2:0] pull, input logic [2:0] ratio, input logic [2:0] band,
      input logic [8:0] k2, input logic [11:0] e_max, e_khz, e_adr, e_hys, e_mid);
    i_phase_sense_input_pulled = pull;
    i_address_frequency_strap_ratio = ratio;
    i_address_frequency_strap_band = band;
    i_second_phase_drive_strap_kohm = k2;
    i_reset = 1'b1;
    cyc(12);
    i_reset = 1'b0;
    cyc(8);
    i_address_frequency_strap_ratio = ~ratio;
    cyc(3);
    chk(o_max_phases, e_max);
    chk(o_switch_freq_khz, e_khz);
    chk(o_smbus_address, e_adr);
    chk(o_shed_hysteresis_mv, e_hys);
    chk(o_middle_drive_enable, e_mid);
  endtask
  task automatic t_boot();
    i_enable = 1'b1;
    wait_active(3'h2);
    chk(o_cold_boot, 1'b1);
    chk(o_mode, 2'h2);
    chk(o_ocp_threshold_mv, 12'h41A);
    i_enable = 1'b0;
    cyc(6);
    chk(o_running, 1'b0);
    i_enable = 1'b1;
    wait_active(3'h3);
    chk(o_cold_boot, 1'b0);
    chk(o_ocp_threshold_mv, 12'h627);
  endtask
  task automatic t_shed();
    i_power_state_input_mv = 12'h3E8;
    i_power_good = 1'b1;
    i_pwm_middle_request = 4'h1;
    cyc(6);
    chk(o_shed_active, 1'b0);
    chk(o_active_phases, 3'h4);
    i_voltage_code_input = 1'b1;
    cyc(2);
    i_voltage_code_input = 1'b0;
    wait_active(3'h1);
    chk(o_shed_active, 1'b1);
    chk(o_ocp_threshold_mv, 12'h313);
    i_total_current_monitor_mv = 12'h1C2;
    wait_active(3'h2);
    chk(o_interleave_deg, 9'h0B4);
    chk(o_pwm_out, 4'h2);
    chk(o_pwm_middle, 4'hD);
    chk(pin_mid, 4'hD);
    i_pwm_middle_request = 4'h0;
    i_total_current_monitor_mv = 12'h384;
    wait_active(3'h4);
    i_total_current_monitor_mv = 12'h1F4;
    cyc(8);
    chk(o_active_phases, 3'h4);
    i_total_current_monitor_mv = 12'h064;
    wait_active(3'h1);
    i_zone_low_phases = 3'h2;
    wait_active(3'h4);
    i_zone_low_phases = 3'h1;
  endtask
  task automatic t_ocp();
    i_power_state_input_mv = 12'h708;
    i_smbus_phase_valid = 1'b1;
    i_smbus_phases = 3'h3;
    wait_active(3'h3);
    chk(o_mode, 2'h0);
    load_mv[11:0] = 12'h300;
    cyc(2);
    chk(o_channel_limit, 4'h1);
    chk(o_running, 1'b1);
    load_mv[11:0] = 12'h100;
    i_total_current_monitor_mv = 12'h640;
    cyc(3);
    chk(o_over_current_protection, 1'b1);
    i_total_current_monitor_mv = 12'h064;
    cyc(8);
    chk(o_pwm_out, 4'h0);
    chk(o_over_current_protection, 1'b1);
    i_enable = 1'b0;
    cyc(6);
    chk(o_over_current_protection, 1'b0);
  endtask
  initial begin
    t_straps(3'h4, 3'h0, 3'h0, 9'h064, 12'h3, 12'h0C8, 12'h048, 12'h014, 12'h0);
    t_straps(3'h0, 3'h7, 3'h4, 9'h118, 12'h4, 12'h7D0, 12'h040, 12'h08C, 12'h1);
    t_boot();
    t_shed();
    t_ocp();
    stop_test();
  end
endmodule // testbench
